// File: hw/adc_output_test_pattern_gen.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "tpg_defines.svh"
// Functional notes
// - pin sync acts only when select bit set
// - seed source bit picks register seed
// - 23-bit lfsr default, 9-bit when selected
// - prbs enable replaces samples with prbs
// - software sync bit restarts all patterns
// - ramp enable gives full-scale repeating ramp
// - toggle enable alternates first and second code
// - fixed enable holds first code constantly
// - second code upper bits from control 3:2
// - first code upper bits from control 1:0
// - first code lower from register 15:6
// - second code lower from register 15:6
// - control register resets to zero
// - 23-bit seed from both seed registers
module adc_output_test_pattern_gen #(
   parameter int fifo_depth = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sync_pin,
   input wire logic sample_clk,
   input wire logic [11:0] adc_sample,
   output logic [11:0] out_sample,
   output logic out_valid,
   output logic out_sync
);
   logic [15:0] ctrl_ff, nxt_ctrl, seed_lo_ff, nxt_seed_lo, seed_hi_ff, nxt_seed_hi;
   logic [15:0] code1_ff, nxt_code1, code2_ff, nxt_code2;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, soft_sync_ff, nxt_soft_sync;
   logic [2:0] pin_sh_ff, clk_sh_ff;
   logic pin_lvl_ff, nxt_pin_lvl, clk_lvl_ff, nxt_clk_lvl;
   logic [22:0] lfsr_ff, nxt_lfsr;
   logic [11:0] ramp_ff, nxt_ramp;
   logic phase_ff, nxt_phase;
   tpg_pkg::sample_type gen, fifo_out;
   tpg_pkg::mode_type mode;
   logic [11:0] out_ff, nxt_out;
   logic valid_ff, nxt_valid, osync_ff, nxt_osync;
   logic pending_ff, nxt_pending;
   logic tick, sync_evt, fifo_ready, fifo_valid, access, known;
   logic [7:0] idx;
   logic [11:0] first_code, second_code;
   logic [22:0] start_seed;

   function automatic logic [22:0] lfsr_step(input logic [22:0] v, input logic short_sel);
      logic fb;
      fb = short_sel ? (v[8] ^ v[4]) : (v[22] ^ v[17]);
      lfsr_step = short_sel ? {14'h0000, v[7:0], fb} : {v[21:0], fb};
   endfunction : lfsr_step

   // apb: zero wait states, word index from paddr[9:2]
   always_comb begin
      idx = paddr[9:2];
      access = psel && penable;
      known = idx inside {`IDX_SEED_LOW, `IDX_SEED_HIGH, `IDX_PATTERN_CONTROL,
                          `IDX_FIRST_CODE_LOW, `IDX_SECOND_CODE_LOW, `IDX_STATUS};
      nxt_ctrl = ctrl_ff;
      nxt_seed_lo = seed_lo_ff;
      nxt_seed_hi = seed_hi_ff;
      nxt_code1 = code1_ff;
      nxt_code2 = code2_ff;
      nxt_soft_sync = 1'b0;
      nxt_pready = psel && !penable;
      nxt_pslverr = psel && !penable && !(known && paddr[1:0] == 2'h0);
      nxt_prdata = 32'h00000000;
      if (psel && !penable && !pwrite) begin
         case (idx)
            `IDX_SEED_LOW: nxt_prdata = {16'h0000, seed_lo_ff};
            `IDX_SEED_HIGH: nxt_prdata = {16'h0000, seed_hi_ff};
            `IDX_PATTERN_CONTROL: nxt_prdata = {16'h0000, ctrl_ff};
            `IDX_FIRST_CODE_LOW: nxt_prdata = {16'h0000, code1_ff};
            `IDX_SECOND_CODE_LOW: nxt_prdata = {16'h0000, code2_ff};
            `IDX_STATUS: nxt_prdata = {20'h00000, fifo_valid, 1'b0, mode, lfsr_ff[7:0]};
            default: nxt_prdata = 32'h00000000;
         endcase
      end
      if (access && pready_ff && pwrite && !pslverr_ff) begin
         case (idx)
            `IDX_SEED_LOW: nxt_seed_lo = pwdata[15:0];
            `IDX_SEED_HIGH: nxt_seed_hi = pwdata[15:0];
            `IDX_PATTERN_CONTROL: begin
               nxt_ctrl = pwdata[15:0];
               nxt_soft_sync = pwdata[`POS_SOFT_SYNC];
            end
            `IDX_FIRST_CODE_LOW: nxt_code1 = pwdata[15:0];
            `IDX_SECOND_CODE_LOW: nxt_code2 = pwdata[15:0];
            default: nxt_ctrl = ctrl_ff;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= `REG_RESET;
         seed_lo_ff <= `REG_RESET;
         seed_hi_ff <= `REG_RESET;
         code1_ff <= `REG_RESET;
         code2_ff <= `REG_RESET;
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         soft_sync_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         seed_lo_ff <= nxt_seed_lo;
         seed_hi_ff <= nxt_seed_hi;
         code1_ff <= nxt_code1;
         code2_ff <= nxt_code2;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         soft_sync_ff <= nxt_soft_sync;
      end
   end

   // pin inputs: three stages, level moves when the last two agree
   always_comb begin
      nxt_pin_lvl = (pin_sh_ff[1] == pin_sh_ff[2]) ? pin_sh_ff[2] : pin_lvl_ff;
      nxt_clk_lvl = (clk_sh_ff[1] == clk_sh_ff[2]) ? clk_sh_ff[2] : clk_lvl_ff;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sh_ff <= 3'h0;
         clk_sh_ff <= 3'h0;
         pin_lvl_ff <= 1'b0;
         clk_lvl_ff <= 1'b0;
      end else begin
         pin_sh_ff <= {pin_sh_ff[1:0], sync_pin};
         clk_sh_ff <= {clk_sh_ff[1:0], sample_clk};
         pin_lvl_ff <= nxt_pin_lvl;
         clk_lvl_ff <= nxt_clk_lvl;
      end
   end

   // pattern generation, one step per sample clock rising edge
   always_comb begin
      tick = nxt_clk_lvl && !clk_lvl_ff;
      first_code = {ctrl_ff[1:0], code1_ff[15:6]};
      second_code = {ctrl_ff[3:2], code2_ff[15:6]};
      start_seed = ctrl_ff[`POS_SEED_SOURCE] ? {seed_hi_ff[15:9], seed_lo_ff}
                                             : `LFSR_DEFAULT_SEED;
      if (ctrl_ff[`POS_SHORT_LFSR]) begin
         start_seed = {14'h0000, start_seed[8:0]};
      end
      if (start_seed == 23'h000000) begin
         start_seed = 23'h000001; // all-zero would lock the lfsr
      end
      // a sync that lands outside a tick waits for the next one
      nxt_pending = pending_ff || soft_sync_ff
                    || (ctrl_ff[`POS_PIN_SYNC] && nxt_pin_lvl && !pin_lvl_ff);
      sync_evt = tick && nxt_pending;
      if (tick) begin
         nxt_pending = 1'b0;
      end
      if (ctrl_ff[`POS_PRBS_EN]) begin
         mode = tpg_pkg::mode_prbs;
      end else if (ctrl_ff[`POS_RAMP_EN]) begin
         mode = tpg_pkg::mode_ramp;
      end else if (ctrl_ff[`POS_TOGGLE_EN] || ctrl_ff[`POS_FIXED_EN]) begin
         mode = tpg_pkg::mode_code;
      end else begin
         mode = tpg_pkg::mode_normal;
      end
      // a length change without a sync keeps the old state; only a sync reloads a legal seed
      nxt_lfsr = lfsr_ff;
      nxt_ramp = ramp_ff;
      nxt_phase = phase_ff;
      if (sync_evt) begin
         nxt_lfsr = start_seed;
         nxt_ramp = 12'h000;
         nxt_phase = 1'b0;
      end else if (tick) begin
         nxt_lfsr = lfsr_step(lfsr_ff, ctrl_ff[`POS_SHORT_LFSR]);
         nxt_ramp = ramp_ff + 12'h001;
         nxt_phase = !phase_ff;
      end
      case (mode)
         tpg_pkg::mode_prbs: gen.data = lfsr_ff[11:0];
         tpg_pkg::mode_ramp: gen.data = ramp_ff;
         tpg_pkg::mode_code: gen.data = (ctrl_ff[`POS_TOGGLE_EN] && phase_ff) ? second_code
                                                                             : first_code;
         default: gen.data = adc_sample;
      endcase
      gen.sync = sync_evt;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lfsr_ff <= `LFSR_DEFAULT_SEED;
         ramp_ff <= 12'h000;
         phase_ff <= 1'b0;
         pending_ff <= 1'b0;
      end else begin
         lfsr_ff <= nxt_lfsr;
         ramp_ff <= nxt_ramp;
         phase_ff <= nxt_phase;
         pending_ff <= nxt_pending;
      end
   end

   // out_ready is tied high, so the fifo never fills and no tick is lost
   sample_fifo #(.width(13), .depth(fifo_depth)) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(tick),
      .in_ready(fifo_ready),
      .in_data(gen),
      .out_valid(fifo_valid),
      .out_ready(1'b1),
      .out_data(fifo_out)
   );

   always_comb begin
      nxt_valid = fifo_valid;
      nxt_out = fifo_valid ? fifo_out.data : out_ff;
      nxt_osync = fifo_valid && fifo_out.sync;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_ff <= 12'h000;
         valid_ff <= 1'b0;
         osync_ff <= 1'b0;
      end else begin
         out_ff <= nxt_out;
         valid_ff <= nxt_valid;
         osync_ff <= nxt_osync;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign out_sample = out_ff;
   assign out_valid = valid_ff;
   assign out_sync = osync_ff;

   // bus side checks
   a_ctrl_reset: assert property (@(posedge pclk) $rose(presetn) |-> ctrl_ff == 16'h0000)
      else $error("control not zero after reset");
   a_code_write: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pready_ff && pwrite && !pslverr_ff && idx == `IDX_FIRST_CODE_LOW)
      |=> code1_ff == 16'($past(pwdata)))
      else $error("code write lost");
   a_refused_write: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && pslverr_ff) |=> $stable(ctrl_ff))
      else $error("refused write changed control");
   a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready held too long");
   a_error_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("pslverr without pready");
   a_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:16] == 16'h0000)
      else $error("read upper half not zero");

   // pattern side checks
   a_soft_sync_restart: assert property (@(posedge pclk) disable iff (!presetn)
      soft_sync_ff |=> (ramp_ff == 12'h000 || pending_ff))
      else $error("soft sync did not restart");
   a_soft_sync_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      soft_sync_ff |=> !soft_sync_ff)
      else $error("soft sync held too long");
   a_pending_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (pending_ff && !tick) |=> pending_ff)
      else $error("pending sync lost");
   a_pin_sync_gated: assert property (@(posedge pclk) disable iff (!presetn)
      (!ctrl_ff[15] && !soft_sync_ff && !pending_ff) |=> !pending_ff)
      else $error("pin sync acted while disabled");
   a_ramp_step: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !sync_evt) |=> ramp_ff == $past(ramp_ff) + 12'h001)
      else $error("ramp did not step");
   a_ramp_sync_zero: assert property (@(posedge pclk) disable iff (!presetn)
      sync_evt |=> ramp_ff == 12'h000)
      else $error("ramp not restarted");
   a_toggle_first: assert property (@(posedge pclk) disable iff (!presetn)
      sync_evt |=> !phase_ff)
      else $error("toggle not on first code");
   a_toggle_steps: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !sync_evt) |=> phase_ff != $past(phase_ff))
      else $error("toggle did not change");
   a_fixed_code: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == tpg_pkg::mode_code && !ctrl_ff[5]) |-> gen.data == {ctrl_ff[1:0], code1_ff[15:6]})
      else $error("fixed code wrong");
   a_first_code: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == tpg_pkg::mode_code && ctrl_ff[5] && !phase_ff) |-> gen.data == {ctrl_ff[1:0], code1_ff[15:6]})
      else $error("first code wrong");
   a_second_code: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == tpg_pkg::mode_code && ctrl_ff[5] && phase_ff) |-> gen.data == {ctrl_ff[3:2], code2_ff[15:6]})
      else $error("second code wrong");
   a_normal_pass: assert property (@(posedge pclk) disable iff (!presetn)
      mode == tpg_pkg::mode_normal |-> gen.data == adc_sample)
      else $error("normal samples not passed");
   a_seed_load: assert property (@(posedge pclk) disable iff (!presetn)
      (sync_evt && ctrl_ff[14] && !ctrl_ff[13] && {seed_hi_ff[15:9], seed_lo_ff} != 23'h000000)
      |=> (lfsr_ff[15:0] == $past(seed_lo_ff) && lfsr_ff[22:16] == 7'($past(seed_hi_ff) >> 9)))
      else $error("seed not loaded");
   a_short_lfsr: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && ctrl_ff[13]) |=> lfsr_ff[22:9] == 14'h0000)
      else $error("short lfsr uses high bits");
   a_long_shift: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !sync_evt && !ctrl_ff[13]) |=> lfsr_ff[22:1] == 22'($past(lfsr_ff)))
      else $error("long lfsr did not shift");
   a_short_shift: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !sync_evt && ctrl_ff[13]) |=> lfsr_ff[8:1] == 8'($past(lfsr_ff)))
      else $error("short lfsr did not shift");
   a_prbs_out: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_ff[12] |-> gen.data == lfsr_ff[11:0])
      else $error("prbs not selected");

   // stream side checks, then pattern covers
   a_fifo_no_drop: assert property (@(posedge pclk) disable iff (!presetn)
      tick |-> fifo_ready)
      else $error("sample dropped at fifo");
   a_out_follows: assert property (@(posedge pclk) disable iff (!presetn)
      fifo_valid |=> out_valid)
      else $error("output valid missing");
   c_prbs: cover property (@(posedge pclk) ctrl_ff[12] && tick);
   c_ramp_wrap: cover property (@(posedge pclk) ramp_ff == 12'hfff && tick);
   c_pin_sync: cover property (@(posedge pclk) ctrl_ff[15] && sync_evt);
   c_toggle: cover property (@(posedge pclk) ctrl_ff[5] && phase_ff && tick);
   c_soft_sync: cover property (@(posedge pclk) soft_sync_ff && ctrl_ff[6]);
endmodule : adc_output_test_pattern_gen

// File: hw/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
   parameter int width = 13,
   parameter int depth = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [width-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [width-1:0] out_data
);
   localparam int aw = $clog2(depth);
   logic [width-1:0] mem_ff [depth];
   logic [aw:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
   logic push, pop;
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      nxt_wr = wr_ff + (aw+1)'(push);
      nxt_rd = rd_ff + (aw+1)'(pop);
      in_ready = (wr_ff - rd_ff) != (aw+1)'(depth);
      out_valid = wr_ff != rd_ff;
      out_data = mem_ff[rd_ff[aw-1:0]];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
      end
   end
   always_ff @(posedge pclk) begin
      if (push) begin
         mem_ff[wr_ff[aw-1:0]] <= in_data;
      end
   end
endmodule : sample_fifo

// File: hw/tpg_defines.svh
`ifndef TPG_DEFINES_SVH
`define TPG_DEFINES_SVH
// register indices as printed; byte address is four times the index
`define IDX_SEED_LOW 8'h23
`define IDX_SEED_HIGH 8'h24
`define IDX_PATTERN_CONTROL 8'h25
`define IDX_FIRST_CODE_LOW 8'h26
`define IDX_SECOND_CODE_LOW 8'h27
`define IDX_STATUS 8'h30
`define REG_RESET 16'h0000
`define POS_PIN_SYNC 15
`define POS_SEED_SOURCE 14
`define POS_SHORT_LFSR 13
`define POS_PRBS_EN 12
`define POS_SOFT_SYNC 8
`define POS_RAMP_EN 6
`define POS_TOGGLE_EN 5
`define POS_FIXED_EN 4
`define LFSR_DEFAULT_SEED 23'h7fffff
`endif

// File: hw/tpg_pkg.sv
package tpg_pkg;
   typedef enum logic [1:0] {
      mode_normal = 2'b00,
      mode_prbs = 2'b01,
      mode_ramp = 2'b11,
      mode_code = 2'b10
   } mode_type;
   typedef struct packed {
      logic [11:0] data;
      logic sync;
   } sample_type;
endpackage : tpg_pkg

// File: verification/adc_output_test_pattern_gen_tb.sv
`timescale 1ns/1ps
`include "tpg_defines.svh"
module adc_output_test_pattern_gen_tb;
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] code;
      logic [11:0] adc;
      logic [11:0] exp;
   } row_type;
   logic pclk, presetn, psel, penable, pwrite, sync_pin, sample_clk;
   logic pready, pslverr, out_valid, out_sync, cap_sync, cap_seen, er, s;
   logic [11:0] paddr, adc_sample, out_sample, cap_data, d;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] sync_count, n0;
   logic [11:0] seq [0:511];
   int err_count, num_checks;
   // single-code rows keep toggle and ramp clear
   row_type rows [4] = '{
      '{16'h0000, 16'h0000, 12'h5a3, 12'h5a3},
      '{16'h0013, 16'hffff, 12'h5a3, 12'hfff},
      '{16'h0012, 16'h803f, 12'h000, 12'ha00},
      '{16'h0011, 16'h0040, 12'h000, 12'h401}
   };
   adc_output_test_pattern_gen #(.fifo_depth(8)) i_adc_output_test_pattern_gen (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sync_pin(sync_pin), .sample_clk(sample_clk), .adc_sample(adc_sample),
      .out_sample(out_sample), .out_valid(out_valid), .out_sync(out_sync));
   sample_capture i_sample_capture (.pclk(pclk), .presetn(presetn), .out_valid(out_valid),
      .out_sample(out_sample), .out_sync(out_sync), .data_ff(cap_data), .sync_ff(cap_sync), .seen_ff(cap_seen),
      .sync_count_ff(sync_count));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // free running, eight pclk periods long, each edge 13 ns ahead of a pclk rising edge
   initial begin
      sample_clk = 1'b0;
      #7;
      forever #160 sample_clk = ~sample_clk;
   end
   task stop_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // answer read right after the rising edge sees the value sampled at that edge
   task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task get(output logic [11:0] gd, output logic gs);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (cap_seen !== 1'b1 && n < 40);
      if (cap_seen !== 1'b1) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, cap_seen, 1'b1);
      end
      gd = cap_data;
      gs = cap_sync;
   endtask : get
   task sync_wait(output logic ws);
      int n;
      n = 0;
      do begin
         get(d, ws);
         n++;
      end while (ws !== 1'b1 && n < 10);
   endtask : sync_wait
   initial begin
      #3000000;
      err_count++;
      stop_test();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sync_pin = 1'b0;
      adc_sample = 12'h000;
      err_count = 0;
      num_checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `IDX_PATTERN_CONTROL, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, `IDX_FIRST_CODE_LOW, 32'ha5c3);
      apb(1'b0, `IDX_FIRST_CODE_LOW, 32'h0);
      check(rd, 32'ha5c3);
      apb(1'b0, 8'h3f, 32'h0);
      check({31'h0, er}, 32'h1);
      $display("test registers done");
      foreach (rows[i]) begin
         apb(1'b1, `IDX_PATTERN_CONTROL, {16'h0, rows[i].ctrl});
         apb(1'b1, `IDX_FIRST_CODE_LOW, {16'h0, rows[i].code});
         adc_sample <= rows[i].adc;
         repeat (3) get(d, s);
         check(d, rows[i].exp);
      end
      $display("test table done");
      apb(1'b1, `IDX_FIRST_CODE_LOW, 32'h1240);
      apb(1'b1, `IDX_SECOND_CODE_LOW, 32'hfffc);
      apb(1'b1, `IDX_PATTERN_CONTROL, 32'h0126);
      sync_wait(s);
      check(s, 1'b1);
      for (int k = 0; k < 4; k++) begin
         get(d, s);
         check(d, k[0] ? 12'h7ff : 12'h849);
      end
      $display("test toggle done");
      apb(1'b1, `IDX_PATTERN_CONTROL, 32'h0140);
      sync_wait(s);
      check(s, 1'b1);
      // one full lap plus one, so the wrap to zero is seen
      for (int k = 0; k <= 4096; k++) begin
         get(d, s);
         check(d, k[11:0]);
      end
      $display("test ramp done");
      apb(1'b1, `IDX_PATTERN_CONTROL, 32'h0040);
      n0 = sync_count;
      sync_pin <= 1'b1;
      repeat (20) @(posedge pclk);
      sync_pin <= 1'b0;
      repeat (40) @(posedge pclk);
      check(sync_count, n0);
      apb(1'b1, `IDX_PATTERN_CONTROL, 32'h8040);
      sync_pin <= 1'b1;
      sync_wait(s);
      @(posedge pclk);
      sync_pin <= 1'b0;
      check(s, 1'b1);
      get(d, s);
      check(d, 12'h000);
      $display("test pin sync done");
      apb(1'b1, `IDX_SEED_LOW, 32'habcd);
      apb(1'b1, `IDX_SEED_HIGH, 32'h5400);
      apb(1'b1, `IDX_PATTERN_CONTROL, 32'h5100);
      sync_wait(s);
      get(d, s);
      check(d, 12'hbcd);
      apb(1'b1, `IDX_PATTERN_CONTROL, 32'h1100);
      sync_wait(s);
      get(d, s);
      check(d, 12'hfff);
      // short generator repeats after 511 steps, the long one does not
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, `IDX_PATTERN_CONTROL, m == 0 ? 32'h3100 : 32'h1100);
         sync_wait(s);
         for (int k = 0; k < 512; k++) begin
            get(seq[k], s);
         end
         check({31'h0, seq[511] == seq[0]}, m == 0 ? 32'h1 : 32'h0);
      end
      apb(1'b0, `IDX_STATUS, 32'h0);
      check({30'h0, rd[9:8]}, {30'h0, tpg_pkg::mode_prbs});
      $display("test prbs done");
      // second reset in mid-run, control must come back cleared
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `IDX_PATTERN_CONTROL, 32'h0);
      check(rd, 32'h0);
      $display("test reset done");
      stop_test();
   end
endmodule : adc_output_test_pattern_gen_tb

// File: verification/sample_capture.sv
`timescale 1ns/1ps
// receiver side: latches every word that the stream presents
module sample_capture (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic out_valid,
   input wire logic [11:0] out_sample,
   input wire logic out_sync,
   output logic [11:0] data_ff,
   output logic sync_ff,
   output logic seen_ff,
   output logic [7:0] sync_count_ff
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_ff <= 12'h000;
         sync_ff <= 1'b0;
         seen_ff <= 1'b0;
         sync_count_ff <= 8'h00;
      end else begin
         seen_ff <= out_valid;
         if (out_valid) begin
            data_ff <= out_sample;
            sync_ff <= out_sync;
            sync_count_ff <= sync_count_ff + {7'h00, out_sync};
         end
      end
   end
endmodule : sample_capture
